// ===== design/scai_regs.svh
// Constants shared by both ends of the command and address link
`ifndef SCAI_REGS_SVH
`define SCAI_REGS_SVH
`define SCAI_AW        13
`define SCAI_BW        3
`define SCAI_NBANK     8
`define SCAI_DW        16
`define SCAI_COLW      10
`define SCAI_AP_BIT    10
`define SCAI_BC_BIT    12
`define SCAI_BEATS8    4'h8
`define SCAI_BEATS4    4'h4
`define SCAI_BL_FIXED8 2'h0
`define SCAI_BL_OTF    2'h1
`define SCAI_BL_FIXED4 2'h2
`define SCAI_MR_ZERO   2'h0
`define SCAI_MR_ONE    2'h1
`define SCAI_RTT_MASK  13'h0244
// Pin codes {cs_n, ras_n, cas_n, we_n}
`define SCAI_P_MRS     4'h0
`define SCAI_P_REF     4'h1
`define SCAI_P_PRE     4'h2
`define SCAI_P_ACT     4'h3
`define SCAI_P_WR      4'h4
`define SCAI_P_RD      4'h5
`define SCAI_P_NOP     4'h7
// Controller registers, byte offsets
`define SCAI_AXI_AW    8
`define SCAI_REG_CMD   8'h00
`define SCAI_REG_CTRL  8'h04
`define SCAI_REG_WDATA 8'h08
`define SCAI_REG_STAT  8'h0C
`define SCAI_REG_RDATA 8'h10
`define SCAI_CMD_BANK  4
`define SCAI_CMD_ADDR  16
`define SCAI_CMD_CKLOW 31
`define SCAI_CTRL_RST  3'h5
`define SCAI_RESP_OK   2'h0
`define SCAI_RESP_ERR  2'h2
`endif

// ===== design/scai_pkg.sv
// Types and shared functions of the command and address link
package scai_pkg;
`include "scai_regs.svh"
  typedef enum logic [2:0] {
    SCAI_NOP, SCAI_MRS, SCAI_REF, SCAI_PRE, SCAI_ACT, SCAI_WR, SCAI_RD, SCAI_DESEL
  } scai_cmd_t;
  typedef enum logic [1:0] {SCAI_PWR_ON, SCAI_PWR_PPD, SCAI_PWR_APD, SCAI_PWR_SREF} scai_pwr_t;
  typedef enum logic [2:0] {SCAI_C_IDLE, SCAI_C_WAIT, SCAI_C_HOLDA, SCAI_C_HOLDB, SCAI_C_BURST}
    scai_cst_t;

  function automatic scai_cmd_t scai_decode(input logic [3:0] pins);
    scai_cmd_t c;
    c = SCAI_NOP;
    if (pins[3]) c = SCAI_DESEL;
    else if (pins == `SCAI_P_MRS) c = SCAI_MRS;
    else if (pins == `SCAI_P_REF) c = SCAI_REF;
    else if (pins == `SCAI_P_PRE) c = SCAI_PRE;
    else if (pins == `SCAI_P_ACT) c = SCAI_ACT;
    else if (pins == `SCAI_P_WR) c = SCAI_WR;
    else if (pins == `SCAI_P_RD) c = SCAI_RD;
    return c;
  endfunction : scai_decode

  // Beat count of a read or write from mode register zero and the chop bit
  function automatic logic [3:0] scai_beats(input logic [`SCAI_AW-1:0] mr0, input logic a12);
    logic [3:0] n;
    n = `SCAI_BEATS8;
    if (mr0[1:0] == `SCAI_BL_FIXED4) n = `SCAI_BEATS4;
    else if (mr0[1:0] == `SCAI_BL_OTF && !a12) n = `SCAI_BEATS4;
    return n;
  endfunction : scai_beats
endpackage : scai_pkg

// ===== design/scai_if.sv
// Pin-level link between memory controller and memory device
`timescale 1ns/10ps
`include "scai_regs.svh"
interface scai_if;
  import scai_pkg::*;
  logic                  ck_t;
  logic                  ck_c;
  logic                  cke;
  logic                  cs_n;
  logic                  ras_n;
  logic                  cas_n;
  logic                  we_n;
  logic [`SCAI_BW-1:0]   ba;
  logic [`SCAI_AW-1:0]   addr;
  logic                  termination_control;
  logic                  reset_n;
  logic                  lower_byte_mask;
  logic                  upper_byte_mask;
  logic [`SCAI_DW-1:0]   dq_ctl_o;
  logic                  dq_ctl_oe;
  logic [`SCAI_DW-1:0]   dq_dev_o;
  logic                  dq_dev_oe;
  logic [1:0]            strobe_t_o;
  logic [1:0]            strobe_c_o;
  logic [1:0]            strobe_oe;
  logic [`SCAI_DW-1:0]   dq;
  // Undriven bus reads as zero; device wins a clash
  assign dq = dq_dev_oe ? dq_dev_o : (dq_ctl_oe ? dq_ctl_o : '0);
  modport dev (input ck_t, ck_c, cke, cs_n, ras_n, cas_n, we_n, ba, addr,
               termination_control, reset_n, lower_byte_mask, upper_byte_mask, dq,
               output dq_dev_o, dq_dev_oe, strobe_t_o, strobe_c_o, strobe_oe);
  modport ctl (output ck_t, ck_c, cke, cs_n, ras_n, cas_n, we_n, ba, addr,
               termination_control, reset_n, lower_byte_mask, upper_byte_mask,
               dq_ctl_o, dq_ctl_oe, input dq);
endinterface : scai_if

// ===== design/scai_ctrl.sv
// Controller end: AXI4-Lite register slave driving the command and address link
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "scai_regs.svh"
module scai_ctrl
  import scai_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  scai_if.ctl                         link,
  input  wire logic [`SCAI_AXI_AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]             s_axi_awprot,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`SCAI_AXI_AW-1:0] s_axi_araddr,
  input  wire logic [2:0]             s_axi_arprot,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready
);
  typedef struct packed {
    scai_cst_t               st;
    logic                    ck;
    logic                    ck_n;
    logic [3:0]              pins;
    logic [`SCAI_BW-1:0]     ba;
    logic [`SCAI_AW-1:0]     addr;
    logic [2:0]              ctrl;
    logic [`SCAI_DW+1:0]     wreg;
    logic [`SCAI_DW-1:0]     rreg;
    logic [`SCAI_DW-1:0]     dq_o;
    logic                    dq_oe;
    logic [1:0]              dm;
    logic [3:0]              beats;
    logic [32:0]             pend;
    logic [`SCAI_AW-1:0]     mr0;
    logic                    aw_got;
    logic                    w_got;
    logic [`SCAI_AXI_AW-1:0] awaddr;
    logic [31:0]             wdat;
    logic [3:0]              wstrb;
    logic                    awready;
    logic                    wready;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
  } scai_ctl_st_t;

  scai_ctl_st_t q, d;

  // Byte-enable merge, used by the control and write-data registers; a command write takes the whole word
  function automatic logic [31:0] scai_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : scai_merge

  always_comb begin
    logic [31:0] m;
    m = '0;
    d = q;
    d.ck = ~q.ck;
    d.ck_n = q.ck;
    ////////////////////////////////////////////////////////////////////////////////////////
    if (s_axi_awvalid && q.awready) begin
      d.awaddr = s_axi_awaddr;
      d.aw_got = 1'b1;
    end
    if (s_axi_wvalid && q.wready) begin
      d.wdat = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
      d.w_got = 1'b1;
    end
    if (q.bvalid && s_axi_bready) d.bvalid = 1'b0;
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `SCAI_RESP_OK;
      case (q.awaddr)
        `SCAI_REG_CMD: begin
          // A command written while one is still on the link is refused
          if (q.st == SCAI_C_IDLE) begin
            d.pend = {1'b1, q.wdat};
            d.st = SCAI_C_WAIT;
          end else begin
            d.bresp = `SCAI_RESP_ERR;
          end
        end
        `SCAI_REG_CTRL: begin
          m = scai_merge({29'h0, q.ctrl}, q.wdat, q.wstrb);
          d.ctrl = m[2:0];
        end
        `SCAI_REG_WDATA: begin
          m = scai_merge({14'h0, q.wreg}, q.wdat, q.wstrb);
          d.wreg = m[`SCAI_DW+1:0];
        end
        `SCAI_REG_STAT, `SCAI_REG_RDATA: ;
        default: d.bresp = `SCAI_RESP_ERR;
      endcase
    end
    d.awready = !d.aw_got && !d.bvalid;
    d.wready = !d.w_got && !d.bvalid;
    if (q.rvalid && s_axi_rready) d.rvalid = 1'b0;
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = `SCAI_RESP_OK;
      case (s_axi_araddr)
        `SCAI_REG_CTRL: d.rdata = {29'h0, q.ctrl};
        `SCAI_REG_WDATA: d.rdata = {14'h0, q.wreg};
        `SCAI_REG_STAT: d.rdata = {31'h0, q.st != SCAI_C_IDLE};
        `SCAI_REG_RDATA: d.rdata = {16'h0, q.rreg};
        `SCAI_REG_CMD: d.rdata = q.pend[31:0];
        default: begin
          d.rdata = '0;
          d.rresp = `SCAI_RESP_ERR;
        end
      endcase
    end
    d.arready = !d.rvalid;
    ////////////////////////////////////////////////////////////////////////////////////////
    unique case (q.st)
      SCAI_C_IDLE: ;
      SCAI_C_WAIT: begin
        // Launch while the clock falls so the device sees a settled code
        if (q.ck) begin
          d.pins = {1'b0, q.pend[2:0]};
          d.ba = q.pend[`SCAI_CMD_BANK +: `SCAI_BW];
          d.addr = q.pend[`SCAI_CMD_ADDR +: `SCAI_AW];
          if (q.pend[`SCAI_CMD_CKLOW]) d.ctrl[0] = 1'b0;
          if ({1'b0, q.pend[2:0]} == `SCAI_P_MRS && d.ba == {1'b0, `SCAI_MR_ZERO}) begin
            d.mr0 = d.addr;
          end
          d.st = SCAI_C_HOLDA;
        end
      end
      SCAI_C_HOLDA: d.st = SCAI_C_HOLDB;
      SCAI_C_HOLDB: begin
        d.pins = `SCAI_P_NOP | 4'h8;
        d.beats = scai_beats(q.mr0, q.addr[`SCAI_BC_BIT]);
        d.st = SCAI_C_IDLE;
        if (q.pins == `SCAI_P_WR) begin
          d.dq_o = q.wreg[`SCAI_DW-1:0];
          d.dm = q.wreg[`SCAI_DW+1:`SCAI_DW];
          d.dq_oe = 1'b1;
          d.st = SCAI_C_BURST;
        end
        if (q.pins == `SCAI_P_RD) d.st = SCAI_C_BURST;
      end
      SCAI_C_BURST: begin
        d.beats = q.beats - 4'h1;
        if (!q.dq_oe) d.rreg = link.dq;
        if (q.beats == 4'h1) begin
          d.dq_oe = 1'b0;
          d.dm = 2'h0;
          d.st = SCAI_C_IDLE;
        end
      end
    endcase
    if (!q.ctrl[2]) d.mr0 = '0;
    d.pend[32] = d.st != SCAI_C_IDLE;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.pins <= `SCAI_P_NOP | 4'h8;
      q.ck_n <= 1'b1;
      q.ctrl <= `SCAI_CTRL_RST;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign link.ck_t = q.ck;
  assign link.ck_c = q.ck_n;
  assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = q.pins;
  assign link.ba = q.ba;
  assign link.addr = q.addr;
  assign link.cke = q.ctrl[0];
  assign link.termination_control = q.ctrl[1];
  assign link.reset_n = q.ctrl[2];
  assign link.dq_ctl_o = q.dq_o;
  assign link.dq_ctl_oe = q.dq_oe;
  assign link.lower_byte_mask = q.dm[0];
  assign link.upper_byte_mask = q.dm[1];
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
endmodule : scai_ctrl

// ===== design/scai_device.sv
// Device end: command, address and control input stage of the memory
//
// How it works
// - Activate latches row address for its bank
// - Read/write take column; bit ten means autoprecharge
// - Precharge: bit ten low one bank, high all
// - Load mode copies address op-code into register
// - On-the-fly chop: bit twelve selects eight/four beats
// - Bank inputs pick the one bank affected
// - Bank inputs pick mode register zero to three
// - Sample inputs at rising true-clock crossing
// - Read strobes follow the clock crossings
// - Clock enable low: power-down or self refresh
// - Clock enable synchronous, except self-refresh exit
// - Low-power states gate off most input buffers
// - Chip select high masks every command
// - Four strobes decode together as one command
// - Lower mask high drops the lower byte
// - Upper mask high drops the upper byte
// - Termination follows its registered control input
// - Termination disabled in mode register ignores input
// - Memory reset acts asynchronously and holds all state cleared while low
`timescale 1ns/10ps
`include "scai_regs.svh"
module scai_device
  import scai_pkg::*;
(
  input  wire logic                                  aclk,
  input  wire logic                                  aresetn,
  scai_if.dev                                        link,
  output logic [`SCAI_NBANK-1:0]                     bank_open,
  output logic [`SCAI_NBANK-1:0][`SCAI_AW-1:0]       open_rows,
  output logic [3:0][`SCAI_AW-1:0]                   mode_regs,
  output scai_pwr_t                                  power_state,
  output scai_cmd_t                                  last_cmd,
  output logic [`SCAI_BW-1:0]                        access_bank,
  output logic [`SCAI_COLW-1:0]                      access_col,
  output logic                                       auto_precharge,
  output logic                                       burst_chop,
  output logic                                       term_on,
  output logic [`SCAI_NBANK-1:0][`SCAI_DW-1:0]       bank_word
);
  typedef struct packed {
    logic                                ck_prev;
    scai_pwr_t                           pwr;
    logic [`SCAI_NBANK-1:0]              open;
    logic [`SCAI_NBANK-1:0][`SCAI_AW-1:0] row;
    logic [3:0][`SCAI_AW-1:0]            mr;
    logic [`SCAI_NBANK-1:0][`SCAI_DW-1:0] mem;
    scai_cmd_t                           last;
    logic [`SCAI_BW-1:0]                 bank;
    logic [`SCAI_COLW-1:0]               col;
    logic                                ap;
    logic                                chop;
    logic                                odt_reg;
    logic                                term_on;
    logic [3:0]                          beats;
    logic                                wr_burst;
    logic [`SCAI_DW-1:0]                 dq_o;
    logic                                dq_oe;
    logic [1:0]                          strobe_t;
    logic [1:0]                          strobe_c;
    logic [1:0]                          strobe_oe;
  } scai_dev_st_t;

  scai_dev_st_t q, d;
  logic         xing;
  scai_cmd_t    cmd;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Inputs come from logic on aclk, so they are used without synchronisers
  assign xing = link.ck_t & ~link.ck_c & ~q.ck_prev;
  assign cmd = scai_decode({link.cs_n, link.ras_n, link.cas_n, link.we_n});

  always_comb begin
    d = q;
    d.ck_prev = link.ck_t;
    //////////////////////////////////////////////////////////////////////////////////////////
    // Data beats, one per aclk cycle after the command crossing
    if (q.beats != 4'h0) begin
      d.beats = q.beats - 4'h1;
      if (q.wr_burst) begin
        if (!link.lower_byte_mask) begin
          d.mem[q.bank][7:0] = link.dq[7:0];
        end
        if (!link.upper_byte_mask) begin
          d.mem[q.bank][15:8] = link.dq[15:8];
        end
      end else begin
        d.strobe_t = ~q.strobe_t;
        d.strobe_c = q.strobe_t;
      end
      if (q.beats == 4'h1) begin
        d.dq_oe = 1'b0;
        d.strobe_oe = 2'h0;
        d.wr_burst = 1'b0;
      end
    end
    //////////////////////////////////////////////////////////////////////////////////////////
    unique case (q.pwr)
      SCAI_PWR_ON: begin
        if (xing) begin
          d.odt_reg = link.termination_control;
          if (!link.cke) begin
            // Entry command is not executed; only refresh selects self refresh
            if (q.open != '0) begin
              d.pwr = SCAI_PWR_APD;
            end else if (cmd == SCAI_REF) begin
              d.pwr = SCAI_PWR_SREF;
            end else begin
              d.pwr = SCAI_PWR_PPD;
            end
          end else if (cmd != SCAI_DESEL) begin
            d.last = cmd;
            unique case (cmd)
              SCAI_MRS: begin
                // Bank codes four to seven name no mode register
                if (!link.ba[2]) begin
                  d.mr[link.ba[1:0]] = link.addr;
                end
              end
              SCAI_ACT: begin
                d.open[link.ba] = 1'b1;
                d.row[link.ba] = link.addr;
              end
              SCAI_PRE: begin
                if (link.addr[`SCAI_AP_BIT]) begin
                  d.open = '0;
                end else begin
                  d.open[link.ba] = 1'b0;
                end
              end
              SCAI_WR, SCAI_RD: begin
                d.bank = link.ba;
                d.col = link.addr[`SCAI_COLW-1:0];
                d.ap = link.addr[`SCAI_AP_BIT];
                d.beats = scai_beats(q.mr[`SCAI_MR_ZERO], link.addr[`SCAI_BC_BIT]);
                d.chop = d.beats == `SCAI_BEATS4;
                d.wr_burst = cmd == SCAI_WR;
                if (cmd == SCAI_RD) begin
                  d.dq_o = q.mem[link.ba];
                  d.dq_oe = 1'b1;
                  d.strobe_oe = 2'h3;
                  d.strobe_t = 2'h3;
                  d.strobe_c = 2'h0;
                end
                // Closing at the command keeps bank state simple; no row timing
                if (link.addr[`SCAI_AP_BIT]) begin
                  d.open[link.ba] = 1'b0;
                end
              end
              SCAI_REF, SCAI_NOP, SCAI_DESEL: ;
            endcase
          end
        end
      end
      SCAI_PWR_PPD, SCAI_PWR_APD: begin
        // Only clock, clock enable, reset and termination are listened to
        if (xing) begin
          d.odt_reg = link.termination_control;
          if (link.cke) begin
            d.pwr = SCAI_PWR_ON;
          end
        end
      end
      SCAI_PWR_SREF: begin
        // Clock may be stopped here, so exit does not wait for a crossing
        d.odt_reg = 1'b0;
        if (link.cke) begin
          d.pwr = SCAI_PWR_ON;
        end
      end
    endcase
    d.term_on = d.odt_reg && d.pwr != SCAI_PWR_SREF &&
                (q.mr[`SCAI_MR_ONE] & `SCAI_RTT_MASK) != '0;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Memory reset clears all state even while the link clock is stopped
  always_ff @(posedge aclk or negedge link.reset_n) begin
    if (!link.reset_n) begin
      q <= '0;
    end else if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign link.dq_dev_o = q.dq_o;
  assign link.dq_dev_oe = q.dq_oe;
  assign link.strobe_t_o = q.strobe_t;
  assign link.strobe_c_o = q.strobe_c;
  assign link.strobe_oe = q.strobe_oe;
  assign bank_open = q.open;
  assign open_rows = q.row;
  assign mode_regs = q.mr;
  assign power_state = q.pwr;
  assign last_cmd = q.last;
  assign access_bank = q.bank;
  assign access_col = q.col;
  assign auto_precharge = q.ap;
  assign burst_chop = q.chop;
  assign term_on = q.term_on;
  assign bank_word = q.mem;
endmodule : scai_device

// ===== verif/scai_assertions.sv
// Concurrent checks on the link between the controller and device ends
`timescale 1ns/10ps
module scai_checker (
  input logic       aclk,
  input logic       aresetn,
  input logic       ck_t,
  input logic       ck_c,
  input logic       cs_n,
  input logic       ras_n,
  input logic       cas_n,
  input logic       we_n,
  input logic       dq_ctl_oe,
  input logic       dq_dev_oe,
  input logic [1:0] strobe_oe,
  input logic       cke
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////
  a_ck_runs: assert property ($past(aresetn) |-> ck_t != $past(ck_t))
    else $error("link clock stalled");
  a_ck_pair: assert property (ck_c == ~ck_t)
    else $error("clock pair not complementary");
  // Command is launched with ck_t low so the device crossing lands mid-command
  a_cmd_frame: assert property ($fell(cs_n) |-> !ck_t && !cs_n ##1 !cs_n ##1 cs_n)
    else $error("command frame wrong");
  a_desel_idle: assert property (cs_n |-> ras_n && cas_n && we_n)
    else $error("strobes active while deselected");
  a_no_clash: assert property (!(dq_ctl_oe && dq_dev_oe))
    else $error("both ends drive data");
  a_rd_strobe: assert property (dq_dev_oe |-> strobe_oe == 2'h3)
    else $error("read data without strobes");
  a_rd_cause: assert property ($rose(dq_dev_oe) |-> $past({cs_n, ras_n, cas_n, we_n}) == 4'h5)
    else $error("read data without read command");
  a_wr_cause: assert property ($rose(dq_ctl_oe) |-> $past({cs_n, ras_n, cas_n, we_n}) == 4'h4)
    else $error("write data without write command");
  a_rd_beats: assert property ($rose(dq_dev_oe) |-> dq_dev_oe[*4] ##1
    (!dq_dev_oe or (dq_dev_oe[*4] ##1 !dq_dev_oe))) else $error("read burst length");
  a_wr_beats: assert property ($rose(dq_ctl_oe) |-> dq_ctl_oe[*4] ##1
    (!dq_ctl_oe or (dq_ctl_oe[*4] ##1 !dq_ctl_oe))) else $error("write burst length");
  c_read: cover property ($rose(dq_dev_oe));
  c_write: cover property ($rose(dq_ctl_oe));
  c_cke: cover property ($fell(cke));
endmodule : scai_checker

// ===== verif/test_sdram_command_address_input.sv
// Bench driving the controller over AXI4-Lite and watching the device end
`timescale 1ns/10ps
module test_sdram_command_address_input;
  import scai_pkg::*;
  logic             aclk = 1'b0;
  logic             aresetn = 1'b0;
  logic [7:0]       s_axi_awaddr = 8'h00;
  logic [7:0]       s_axi_araddr = 8'h00;
  logic [2:0]       s_axi_awprot = 3'h0;
  logic [2:0]       s_axi_arprot = 3'h0;
  logic [3:0]       s_axi_wstrb = 4'hF;
  logic [31:0]      s_axi_wdata = 32'h0;
  logic             s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic             s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic             s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]       s_axi_bresp, s_axi_rresp;
  logic [31:0]      s_axi_rdata;
  logic [7:0]       bank_open;
  logic [7:0][12:0] open_rows;
  logic [3:0][12:0] mode_regs;
  scai_pwr_t        power_state;
  scai_cmd_t        last_cmd;
  logic [2:0]       access_bank;
  logic [9:0]       access_col;
  logic             auto_precharge, burst_chop, term_on;
  logic [7:0][15:0] bank_word;
  integer           fail_count = 0, check_count = 0, cyc = 0, seed = 32'h11D2;
  logic [1:0]       bq[$];
  logic [34:0]      rq[$];
  always #4 aclk = ~aclk;
  scai_if lk();
  scai_ctrl i_scai_ctrl (.aclk, .aresetn, .link(lk), .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  scai_device i_scai_device (.aclk, .aresetn, .link(lk), .bank_open, .open_rows, .mode_regs,
    .power_state, .last_cmd, .access_bank, .access_col, .auto_precharge, .burst_chop,
    .term_on, .bank_word);
  scai_checker i_scai_checker (.aclk, .aresetn, .ck_t(lk.ck_t), .ck_c(lk.ck_c),
    .cs_n(lk.cs_n), .ras_n(lk.ras_n), .cas_n(lk.cas_n), .we_n(lk.we_n), .cke(lk.cke),
    .dq_ctl_oe(lk.dq_ctl_oe), .dq_dev_oe(lk.dq_dev_oe), .strobe_oe(lk.strobe_oe));
  ////////////////////////////////////////////////////////////
  task close_out();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task cmp_bus(input logic [33:0] g, input logic [33:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp_bus
  task cmp_st(input logic [31:0] g, input logic [31:0] e);
    cmp_bus({2'h0, g}, {2'h0, e});
  endtask : cmp_st
  // Response arrives in the order issued, so the oldest note is the match
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    integer n;
    n = 0;
    @(posedge aclk);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b0;
    end while (s_axi_bready && n < 100);
    if (n >= 100) fail_count++;
  endtask : wr
  // Bit 34 of the note marks whether the read data is to be compared
  task rd(input logic [7:0] a, input logic [34:0] e, output logic [31:0] v);
    integer n;
    n = 0;
    @(posedge aclk);
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        v = s_axi_rdata;
        s_axi_rready <= 1'b0;
      end
    end while (s_axi_rready && n < 100);
    if (n >= 100) fail_count++;
  endtask : rd
  task idle();
    logic [31:0] v;
    integer n;
    n = 0;
    v = 32'h1;
    while (v[0] && n < 40) begin
      rd(8'h0C, 35'h0, v);
      n++;
    end
    if (v[0]) fail_count++;
  endtask : idle
  task cmd(input logic [2:0] c, input logic [2:0] b, input logic [12:0] a, input logic lo);
    wr(8'h00, {lo, 2'h0, a, 9'h000, b, 1'b0, c}, 2'h0);
    idle();
  endtask : cmd
  task ctrl(input logic [2:0] v);
    wr(8'h04, {29'h0, v}, 2'h0);
    idle();
  endtask : ctrl
  ////////////////////////////////////////////////////////////
  always @(posedge aclk) begin : mon
    logic [34:0] e;
    if (s_axi_bvalid && s_axi_bready) cmp_bus({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
    if (s_axi_rvalid && s_axi_rready) begin
      e = rq.pop_front();
      if (e[34]) cmp_bus({s_axi_rresp, s_axi_rdata}, e[33:0]);
    end
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    logic [31:0] v;
    logic [12:0] mv, r1, r2;
    integer i;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h04, 35'h400000005, v);
    rd(8'h20, 35'h600000000, v);
    wr(8'h20, 32'h0, 2'h2);
    cmp_st(last_cmd, SCAI_NOP);
    for (i = 0; i < 4; i++) begin
      mv = 13'($random(seed));
      if (i == 0) mv[1:0] = 2'h1;
      if (i == 1) mv[2] = 1'b1;
      cmd(3'h0, i[2:0], mv, 1'b0);
      cmp_st(mode_regs[i], mv);
    end
    cmd(3'h0, 3'h4, ~mv, 1'b0);
    cmp_st(mode_regs[3], mv);
    r1 = 13'($random(seed));
    r2 = 13'($random(seed));
    cmd(3'h3, 3'h5, r1, 1'b0);
    cmd(3'h3, 3'h2, r2, 1'b0);
    cmp_st(bank_open, 8'h24);
    cmp_st(open_rows[5], r1);
    cmp_st(open_rows[2], r2);
    v = $random(seed);
    wr(8'h08, {16'h0, v[15:0]}, 2'h0);
    cmd(3'h4, 3'h5, {3'h4, v[25:16]}, 1'b0);
    cmp_st(bank_word[5], v[15:0]);
    cmp_st({access_bank, access_col, auto_precharge, burst_chop}, {3'h5, v[25:16], 2'h0});
    wr(8'h08, {14'h0, 2'h1, ~v[15:0]}, 2'h0);
    cmd(3'h4, 3'h5, 13'h0000, 1'b0);
    cmp_st(bank_word[5], {~v[15:8], v[7:0]});
    cmp_st(burst_chop, 1'b1);
    wr(8'h08, {14'h0, 2'h2, 16'h0000}, 2'h0);
    cmd(3'h4, 3'h5, 13'h1000, 1'b0);
    cmp_st(bank_word[5], {~v[15:8], 8'h00});
    cmd(3'h5, 3'h5, 13'h0400, 1'b0);
    rd(8'h10, {19'h40000, ~v[15:8], 8'h00}, v);
    cmp_st({bank_open, auto_precharge}, {8'h04, 1'b1});
    cmd(3'h3, 3'h6, r1, 1'b0);
    cmd(3'h2, 3'h2, 13'h0000, 1'b0);
    cmp_st(bank_open, 8'h40);
    cmp_st(last_cmd, SCAI_PRE);
    ctrl(3'h4);
    cmp_st(power_state, SCAI_PWR_APD);
    ctrl(3'h5);
    cmp_st(power_state, SCAI_PWR_ON);
    cmd(3'h2, 3'h0, 13'h0400, 1'b0);
    cmp_st(bank_open, 8'h00);
    ctrl(3'h4);
    cmp_st(power_state, SCAI_PWR_PPD);
    cmd(3'h3, 3'h0, r1, 1'b0);
    cmp_st(bank_open, 8'h00);
    ctrl(3'h5);
    cmd(3'h1, 3'h0, 13'h0000, 1'b1);
    cmp_st(power_state, SCAI_PWR_SREF);
    ctrl(3'h5);
    cmp_st(power_state, SCAI_PWR_ON);
    cmd(3'h1, 3'h0, 13'h0000, 1'b0);
    cmp_st(last_cmd, SCAI_REF);
    wr(8'h00, 32'h10000065, 2'h0);
    wr(8'h00, 32'h7, 2'h2);
    idle();
    ctrl(3'h7);
    cmp_st(term_on, 1'b1);
    ctrl(3'h5);
    cmp_st(term_on, 1'b0);
    cmd(3'h0, 3'h1, 13'h0000, 1'b0);
    ctrl(3'h7);
    cmp_st(term_on, 1'b0);
    cmd(3'h3, 3'h1, r1, 1'b0);
    ctrl(3'h3);
    cmp_st({bank_open, mode_regs[2]}, 21'h0);
    ctrl(3'h5);
    close_out();
  end
endmodule : test_sdram_command_address_input
